// ---- bench/rfrac_ctrl_checker.sv ----
// Concurrent checks on the ports of the fan, relay and alarm controller
`timescale 1ns/1ps
`include "rfrac_defines.vh"

module rfrac_checker #(
  parameter [63:0] MIN_CYC = 64'h14,
  parameter [63:0] RST_CYC = 64'hA
) (
  input wire        clock,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready_q,
  input wire        comp_demand,
  input wire        defrost_active,
  input wire        dripping_active,
  input wire        comp_run_q,
  input wire        fan_run_q,
  input wire        relay4_q,
  input wire        relay5_q,
  input wire        low_alarm_q,
  input wire        high_alarm_q,
  input wire        defrost_indication_q,
  input wire        reset_indication_q,
  input wire        keys_enable_q,
  input wire        ir_enable_q
);
  // ----------------------------------------
  // Shadow of the configuration word
  // ----------------------------------------
  reg  [31:0] cfg_q;
  reg  [63:0] ind_cnt_q;
  wire        wr_cfg = psel && penable && pready_q && pwrite && (paddr == `RFRAC_A_CFG);

  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_q     <= `RFRAC_CFG_DEF;
      ind_cnt_q <= 64'h0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= pwdata & `RFRAC_CFG_MASK;
      end
      ind_cnt_q <= reset_indication_q ? ind_cnt_q + 64'h1 : 64'h0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_alarm_rise;
    $rose(low_alarm_q || high_alarm_q);
  endsequence
  sequence s_alarm_fn(logic [1:0] fn);
    (cfg_q[5:4] == fn) && (low_alarm_q || high_alarm_q);
  endsequence

  a_defrost_fan_off: assert property (cfg_q[3] && defrost_active |=> !fan_run_q)
    else $error("fans ran during defrost");
  a_drip_fan_off: assert property (dripping_active |=> !fan_run_q [*2])
    else $error("fans ran while dripping");
  a_comp_fan_off: assert property (cfg_q[1:0] == 2'h0 && cfg_q[2] && !comp_demand
    && !comp_run_q |=> !fan_run_q) else $error("fans ran with compressor off");
  a_relay4_close: assert property (s_alarm_fn(2'h1) |-> ##[0:2] relay4_q)
    else $error("relay 4 not closed on alarm");
  a_relay4_open: assert property (s_alarm_fn(2'h2) |-> ##[0:2] !relay4_q)
    else $error("relay 4 not opened on alarm");
  a_relay5_set: assert property (s_alarm_rise |-> ##[0:2] relay5_q)
    else $error("relay 5 not set on alarm");
  a_keys_inhibit: assert property (!sys_rst |=> keys_enable_q ==
    ($past(cfg_q[7:6]) != 2'h0 && $past(cfg_q[7:6]) != 2'h2)) else $error("key enable wrong");
  a_ir_inhibit: assert property (!sys_rst |=> ir_enable_q ==
    ($past(cfg_q[7:6]) != 2'h2 && $past(cfg_q[7:6]) != 2'h3)) else $error("remote enable wrong");
  a_defrost_show: assert property (!sys_rst |=> defrost_indication_q ==
    ($past(defrost_active) && !$past(cfg_q[9]))) else $error("defrost indication wrong");
  a_reset_hold: assert property ($fell(reset_indication_q) |->
    ind_cnt_q >= RST_CYC && ind_cnt_q <= RST_CYC + 64'h1) else $error("reset wait length wrong");
endmodule

bind rfrac_ctrl rfrac_checker #(.MIN_CYC(MIN_CYC), .RST_CYC(RST_CYC)) rfrac_checker_i (
  .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_q, .comp_demand,
  .defrost_active, .dripping_active, .comp_run_q, .fan_run_q, .relay4_q, .relay5_q,
  .low_alarm_q, .high_alarm_q, .defrost_indication_q, .reset_indication_q,
  .keys_enable_q, .ir_enable_q);

// ---- bench/rfrac_ctrl_tb.sv ----
// Self-checking bench of the fan, relay and alarm controller
`timescale 1ns/1ps
`include "rfrac_defines.vh"

module rfrac_ctrl_tb;
  logic        clock = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] amb_temp = 12'h028, evap_temp = 12'h000;
  logic        comp_demand = 1'b0, defrost_active = 1'b0, dripping_active = 1'b0;
  logic        control_sensor_error = 1'b0, ext_alarm = 1'b0, door_in1 = 1'b0;
  logic        mute_key = 1'b0, mute_ir = 1'b0, hours_clear_key = 1'b0, program_key = 1'b0;
  logic        door_in2 = 1'b0, hours_clear_ir = 1'b0;
  wire         pready_q, pslverr_q, fan_run_q, comp_run_q, relay4_q, relay5_q;
  wire         low_alarm_q, high_alarm_q, defrost_indication_q, reset_indication_q;
  wire         keys_enable_q, ir_enable_q;
  wire  [31:0] prdata_q;
  int          error_cnt = 0, samples_checked = 0, i, j;
  logic [31:0] v;
  logic [11:0] ev [3] = '{12'h05F, 12'h059, 12'h057};
  logic [11:0] at [4] = '{12'h01B, 12'h01C, 12'h035, 12'h034};
  logic [6:0]  du [3] = '{7'h00, 7'h64, 7'h02};
  logic [1:0]  ih [4] = '{2'h0, 2'h2, 2'h3, 2'h1};

  rfrac_ctrl #(.MIN_CYC(64'h14), .RST_CYC(64'hA)) rfrac_ctrl_i (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_q, .prdata_q,
    .pslverr_q, .amb_temp, .evap_temp, .comp_demand, .defrost_active, .dripping_active,
    .control_sensor_error, .ext_alarm, .door_in1, .door_in2, .mute_key, .mute_ir,
    .hours_clear_key, .hours_clear_ir, .program_key, .fan_run_q, .comp_run_q,
    .relay4_q, .relay5_q, .low_alarm_q, .high_alarm_q, .defrost_indication_q,
    .reset_indication_q, .keys_enable_q, .ir_enable_q);

  always #12.5 clock = ~clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bt(input string nm, input logic s, input logic e);
    chk(nm, {31'h0, s}, {31'h0, e});
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready_q !== 1'b1);
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk(nm, {31'h0, e}, {31'h0, xe});
  endtask
  // One-cycle press: 0 mute key, 1 mute remote, 2 clear key, 3 clear remote
  task pulse(input int k);
    if (k == 0) mute_key <= 1'b1;
    else if (k == 1) mute_ir <= 1'b1;
    else if (k == 2) hours_clear_key <= 1'b1;
    else hours_clear_ir <= 1'b1;
    @(posedge clock);
    {mute_key, mute_ir, hours_clear_key, hours_clear_ir} <= 4'h0;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    rd("cfg", 8'h00, 32'h0000124C, 1'b0);
    rd("setp", 8'h04, 32'h00320028, 1'b0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd("diff", 8'h0C, 32'h00000FFF, 1'b0);
    wr(8'h1C, 32'h00000005);
    rd("hours_ro", 8'h1C, 32'h0, 1'b0);
    wr(8'h40, 32'hFFFFFFFF);
    rd("unmapped", 8'h40, 32'h0, 1'b1);
    wr(8'h0C, 32'h00000002);
    $display("test registers done");
    comp_demand <= 1'b1;
    tick(3); bt("fan_mode0", fan_run_q, 1'b1);
    defrost_active <= 1'b1;
    tick(3); bt("fan_defrost", fan_run_q, 1'b0);
    bt("df_hidden", defrost_indication_q, 1'b0);
    wr(8'h00, 32'h0000104C);
    tick(2); bt("df_shown", defrost_indication_q, 1'b1);
    defrost_active <= 1'b0;
    dripping_active <= 1'b1;
    tick(3); bt("fan_drip", fan_run_q, 1'b0);
    dripping_active <= 1'b0;
    tick(5); bt("fan_postdrip", fan_run_q, 1'b0);
    tick(30); bt("fan_back", fan_run_q, 1'b1);
    comp_demand <= 1'b0;
    tick(3); bt("fan_compoff", fan_run_q, 1'b0);
    wr(8'h00, 32'h0000124D);
    amb_temp <= 12'h064;
    evap_temp <= 12'h028;
    tick(3); bt("fan_diff_on", fan_run_q, 1'b1);
    evap_temp <= 12'h03C;
    tick(3); bt("fan_diff_off", fan_run_q, 1'b0);
    wr(8'h00, 32'h0000124E);
    for (i = 0; i < 3; i++) begin
      evap_temp <= ev[i];
      tick(3); bt("fan_evap", fan_run_q, i == 2);
    end
    $display("test fans done");
    wr(8'h00, 32'h0000124C);
    amb_temp <= 12'h000;
    tick(3); bt("low_disabled", low_alarm_q, 1'b0);
    wr(8'h08, 32'h000A000A);
    for (i = 0; i < 4; i++) begin
      amb_temp <= at[i];
      tick(3); bt("low", low_alarm_q, i == 0);
      bt("high", high_alarm_q, i == 2);
    end
    $display("test alarms done");
    wr(8'h00, 32'h0000125C);
    amb_temp <= 12'h028;
    pulse(0);
    tick(3); bt("r4_idle", relay4_q, 1'b0);
    amb_temp <= 12'h01B;
    tick(4); bt("r4_alarm", relay4_q, 1'b1);
    bt("r5_alarm", relay5_q, 1'b1);
    pulse(0);
    tick(3); bt("r4_pending", relay4_q, 1'b1);
    bt("r5_muted", relay5_q, 1'b0);
    amb_temp <= 12'h028;
    tick(3); bt("r4_latched", relay4_q, 1'b1);
    pulse(0);
    tick(3); bt("r4_cleared", relay4_q, 1'b0);
    wr(8'h00, 32'h0000126C);
    tick(3); bt("r4_energised", relay4_q, 1'b1);
    amb_temp <= 12'h01B;
    tick(4); bt("r4_dropped", relay4_q, 1'b0);
    amb_temp <= 12'h028;
    tick(1);
    pulse(1);
    tick(3); bt("r4_restored", relay4_q, 1'b1);
    bt("r5_ir_muted", relay5_q, 1'b0);
    wr(8'h00, 32'h0000124C);
    wr(8'h10, 32'h00050000);
    door_in1 <= 1'b1;
    tick(3); bt("light_on", relay4_q, 1'b1);
    door_in1 <= 1'b0;
    tick(3); bt("light_off", relay4_q, 1'b0);
    wr(8'h10, 32'h00500000);
    door_in2 <= 1'b1;
    tick(3); bt("light2_on", relay4_q, 1'b1);
    $display("test relays done");
    for (i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0000120C | ({30'h0, ih[i]} << 6));
      tick(3); bt("keys", keys_enable_q, ih[i] != 2'h0 && ih[i] != 2'h2);
      bt("remote", ir_enable_q, ih[i] != 2'h2 && ih[i] != 2'h3);
    end
    $display("test inhibit done");
    for (i = 0; i < 2; i++) begin
      for (j = 0; j < 3; j++) begin
        v = {25'h0, du[j]};
        wr(8'h10, (i == 1) ? ((v << 8) | 32'h00010000) : v);
        comp_demand <= (j == 0);
        if (i == 1) ext_alarm <= 1'b1;
        else control_sensor_error <= 1'b1;
        tick(20); bt("duty", comp_run_q, j != 0);
        if (j == 2) begin
          tick(40); bt("duty_off", comp_run_q, 1'b0);
          tick(300); bt("duty_on", comp_run_q, 1'b1);
        end
        control_sensor_error <= 1'b0;
        ext_alarm <= 1'b0;
        tick(3);
      end
    end
    $display("test duty done");
    wr(8'h00, 32'h0000134C);
    amb_temp <= 12'h01E;
    tick(3);
    amb_temp <= 12'h046;
    tick(3);
    amb_temp <= 12'h014;
    tick(3);
    rd("minmax", 8'h18, 32'h00140046, 1'b0);
    tick(1300);
    rd("hours", 8'h1C, 32'h00000001, 1'b0);
    pulse(2);
    tick(3);
    rd("hours_clr", 8'h1C, 32'h0, 1'b0);
    rd("minmax_clr", 8'h18, 32'h00140014, 1'b0);
    amb_temp <= 12'h01E;
    tick(3);
    pulse(3);
    tick(3);
    rd("minmax_ir", 8'h18, 32'h001E001E, 1'b0);
    $display("test recording done");
    program_key <= 1'b1;
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(3); bt("reset_ind", reset_indication_q, 1'b1);
    tick(15); bt("reset_ind_end", reset_indication_q, 1'b0);
    program_key <= 1'b0;
    rd("hours_lost", 8'h1C, 32'h0, 1'b0);
    rd("minmax_lost", 8'h18, 32'h0, 1'b0);
    rd("cfg_default", 8'h00, 32'h0000124C, 1'b0);
    $display("test power up done");
    complete_run;
  end
endmodule

// ---- src/rfrac_ctrl.v ----
// Fan, relay, duty and temperature alarm control with APB registers
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rfrac_defines.vh"

module rfrac_ctrl #(
  parameter [63:0] MIN_CYC = `RFRAC_MIN_S * `RFRAC_CLK_HZ,
  parameter [63:0] RST_CYC = `RFRAC_RST_WAIT_S * `RFRAC_CLK_HZ
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready_q,
  output reg  [31:0] prdata_q,
  output reg         pslverr_q,
  input  wire [11:0] amb_temp,
  input  wire [11:0] evap_temp,
  input  wire        comp_demand,
  input  wire        defrost_active,
  input  wire        dripping_active,
  input  wire        control_sensor_error,
  input  wire        ext_alarm,
  input  wire        door_in1,
  input  wire        door_in2,
  input  wire        mute_key,
  input  wire        mute_ir,
  input  wire        hours_clear_key,
  input  wire        hours_clear_ir,
  input  wire        program_key,
  output reg         fan_run_q,
  output reg         comp_run_q,
  output reg         relay4_q,
  output reg         relay5_q,
  output reg         low_alarm_q,
  output reg         high_alarm_q,
  output reg         defrost_indication_q,
  output reg         reset_indication_q,
  output reg         keys_enable_q,
  output reg         ir_enable_q
);

  localparam [31:0] MIN_L = MIN_CYC[31:0];
  localparam [31:0] RST_L = RST_CYC[31:0];
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  function [13:0] sx;
    input [11:0] v;
    begin
      sx = {{2{v[11]}}, v};
    end
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg  [31:0] cfg_q;
  reg  [31:0] setp_q;
  reg  [31:0] alarm_q;
  reg  [31:0] diff_q;
  reg  [31:0] duty_q;

  wire [1:0]  fan_mode                 = cfg_q[1:0];
  wire        fan_stop_with_compressor = cfg_q[2];
  wire        fan_stop_in_defrost      = cfg_q[3];
  wire [1:0]  relay4_function          = cfg_q[5:4];
  wire [1:0]  input_inhibit_select     = cfg_q[7:6];
  wire        minmax_record_enable     = cfg_q[8];
  wire        defrost_display_override = cfg_q[9];
  wire        aux_ctrl                 = cfg_q[10];
  wire [3:0]  fan_post_drip_stop_time  = cfg_q[15:12];
  wire [11:0] setpoint                 = setp_q[11:0];
  wire [11:0] fan_activation_offset    = setp_q[27:16];
  wire [11:0] low_alarm_offset         = alarm_q[11:0];
  wire [11:0] high_alarm_offset        = alarm_q[27:16];
  wire [11:0] alarm_fan_differential   = diff_q[11:0];
  wire [6:0]  sensor_fault_duty        = duty_q[6:0];
  wire [6:0]  external_alarm_duty      = duty_q[14:8];
  wire [2:0]  input1_function          = duty_q[18:16];
  wire [2:0]  input2_function          = duty_q[22:20];

  // ----------------------------------------
  // Power-up reset procedure
  // ----------------------------------------
  reg  [2:0]  st_q;
  reg  [31:0] rst_cnt_q;
  wire        load_def = (st_q == ST_WAIT) && (rst_cnt_q == RST_L - 32'h1);

  always @(posedge clock) begin
    if (sys_rst) begin
      st_q               <= ST_CHECK;
      rst_cnt_q          <= 32'h0;
      reset_indication_q <= 1'b0;
    end else begin
      case (st_q)
        ST_CHECK: begin
          if (program_key) begin
            st_q               <= ST_WAIT;
            reset_indication_q <= 1'b1;
          end else begin
            st_q <= ST_RUN;
          end
        end
        ST_WAIT: begin
          rst_cnt_q <= rst_cnt_q + 32'h1;
          if (load_def) begin
            st_q               <= ST_RUN;
            reset_indication_q <= 1'b0;
          end
        end
        ST_RUN:  st_q <= ST_RUN;
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  reg         stat_hit;
  reg  [31:0] rdata;
  reg  [11:0] max_q;
  reg  [11:0] min_q;
  reg  [7:0]  hours_q;
  wire [31:0] stat_word = {22'h0, ir_enable_q, keys_enable_q, reset_indication_q,
                           defrost_indication_q, high_alarm_q, low_alarm_q, relay5_q,
                           relay4_q, comp_run_q, fan_run_q};
  wire        wr = psel & penable & pready_q & pwrite & stat_hit;

  always @* begin
    stat_hit = 1'b1;
    case (paddr)
      `RFRAC_A_CFG:    rdata = cfg_q;
      `RFRAC_A_SETP:   rdata = setp_q;
      `RFRAC_A_ALARM:  rdata = alarm_q;
      `RFRAC_A_DIFF:   rdata = diff_q;
      `RFRAC_A_DUTY:   rdata = duty_q;
      `RFRAC_A_STAT:   rdata = stat_word;
      `RFRAC_A_MINMAX: rdata = {4'h0, min_q, 4'h0, max_q};
      `RFRAC_A_HOURS:  rdata = {24'h0, hours_q};
      default: begin
        rdata    = 32'h0;
        stat_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0 : rdata;
      pslverr_q <= ~stat_hit;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst || load_def) begin
      cfg_q   <= `RFRAC_CFG_DEF;
      setp_q  <= `RFRAC_SETP_DEF;
      alarm_q <= `RFRAC_ALARM_DEF;
      diff_q  <= `RFRAC_DIFF_DEF;
      duty_q  <= `RFRAC_DUTY_DEF;
    end else if (wr) begin
      case (paddr)
        `RFRAC_A_CFG:   cfg_q   <= pwdata & `RFRAC_CFG_MASK;
        `RFRAC_A_SETP:  setp_q  <= pwdata & `RFRAC_T_MASK;
        `RFRAC_A_ALARM: alarm_q <= pwdata & `RFRAC_T_MASK;
        `RFRAC_A_DIFF:  diff_q  <= pwdata & `RFRAC_DIFF_MASK;
        `RFRAC_A_DUTY:  duty_q  <= pwdata & `RFRAC_DUTY_MASK;
        default:        cfg_q   <= cfg_q;
      endcase
    end
  end

  // ----------------------------------------
  // Minute time base
  // ----------------------------------------
  reg  [31:0] tick_cnt_q;
  reg         min_tick_q;

  always @(posedge clock) begin
    if (sys_rst || tick_cnt_q == MIN_L - 32'h1) begin
      tick_cnt_q <= 32'h0;
      min_tick_q <= ~sys_rst;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      min_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Key and remote inhibit
  // ----------------------------------------
  wire keys_ok_d = !(input_inhibit_select == `RFRAC_INH_KEYS ||
                     input_inhibit_select == `RFRAC_INH_BOTH);
  wire ir_ok_d   = !(input_inhibit_select == `RFRAC_INH_IR ||
                     input_inhibit_select == `RFRAC_INH_BOTH);
  wire mute      = (mute_key & keys_enable_q) | (mute_ir & ir_enable_q);
  wire hrs_clr   = (hours_clear_key & keys_enable_q) | (hours_clear_ir & ir_enable_q);

  always @(posedge clock) begin
    if (sys_rst) begin
      keys_enable_q <= 1'b0;
      ir_enable_q   <= 1'b0;
    end else begin
      keys_enable_q <= keys_ok_d;
      ir_enable_q   <= ir_ok_d;
    end
  end

  // ----------------------------------------
  // Temperature alarms
  // ----------------------------------------
  wire [13:0] lo_lim = sx(setpoint) - sx(low_alarm_offset) - sx(alarm_fan_differential);
  wire [13:0] hi_lim = sx(setpoint) + sx(high_alarm_offset) + sx(alarm_fan_differential);
  wire        lo_d   = (low_alarm_offset != 12'h0) &&
                       ($signed(sx(amb_temp)) < $signed(lo_lim));
  wire        hi_d   = (high_alarm_offset != 12'h0) &&
                       ($signed(sx(amb_temp)) > $signed(hi_lim));
  wire        alarm_any = low_alarm_q | high_alarm_q | control_sensor_error | ext_alarm;
  reg         alarm_prev_q;
  reg         r4_alm_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      low_alarm_q  <= 1'b0;
      high_alarm_q <= 1'b0;
      alarm_prev_q <= 1'b0;
      r4_alm_q     <= 1'b0;
      relay5_q     <= 1'b0;
    end else begin
      low_alarm_q  <= lo_d;
      high_alarm_q <= hi_d;
      alarm_prev_q <= alarm_any;
      if (alarm_any)
        r4_alm_q <= 1'b1;
      else if (mute)
        r4_alm_q <= 1'b0;
      if (alarm_any && !alarm_prev_q)
        relay5_q <= 1'b1;
      else if (mute)
        relay5_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Relay 4
  // ----------------------------------------
  reg relay4_d;

  always @* begin
    case (relay4_function)
      `RFRAC_R4_AUX: begin
        if (input1_function == `RFRAC_IN_DOOR)
          relay4_d = door_in1;
        else if (input2_function == `RFRAC_IN_DOOR)
          relay4_d = door_in2;
        else
          relay4_d = aux_ctrl;
      end
      `RFRAC_R4_NDE: relay4_d = r4_alm_q;
      `RFRAC_R4_NEN: relay4_d = ~r4_alm_q;
      default:       relay4_d = 1'b0;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst)
      relay4_q <= 1'b0;
    else
      relay4_q <= relay4_d;
  end

  // ----------------------------------------
  // Compressor duty during faults
  // ----------------------------------------
  wire       duty_act = control_sensor_error | ext_alarm;
  wire [6:0] duty_sel = control_sensor_error ? sensor_fault_duty : external_alarm_duty;
  reg        duty_on_q;
  reg  [6:0] duty_cnt_q;
  wire [6:0] duty_nxt = duty_cnt_q + 7'h1;
  reg        comp_d;

  always @(posedge clock) begin
    if (sys_rst || !duty_act) begin
      duty_on_q  <= 1'b1;
      duty_cnt_q <= 7'h0;
    end else if (min_tick_q) begin
      if (duty_on_q ? (duty_nxt >= duty_sel) : (duty_nxt >= `RFRAC_DUTY_OFF)) begin
        duty_on_q  <= ~duty_on_q;
        duty_cnt_q <= 7'h0;
      end else begin
        duty_cnt_q <= duty_nxt;
      end
    end
  end

  always @* begin
    if (!duty_act)
      comp_d = comp_demand;
    else if (duty_sel == 7'h0)
      comp_d = 1'b0;
    else if (duty_sel >= `RFRAC_DUTY_ON)
      comp_d = 1'b1;
    else
      comp_d = duty_on_q;
  end

  always @(posedge clock) begin
    if (sys_rst)
      comp_run_q <= 1'b0;
    else
      comp_run_q <= comp_d;
  end

  // ----------------------------------------
  // Fan control
  // ----------------------------------------
  wire [13:0] fan_hi   = sx(setpoint) + sx(fan_activation_offset);
  wire [13:0] fan_lo   = fan_hi - sx(alarm_fan_differential);
  wire [13:0] amb_gap  = sx(amb_temp) - sx(evap_temp);
  reg         fan_th_q;
  reg         drip_prev_q;
  reg  [3:0]  drip_cnt_q;
  reg         fan_d;

  always @(posedge clock) begin
    if (sys_rst) begin
      fan_th_q    <= 1'b1;
      drip_prev_q <= 1'b0;
      drip_cnt_q  <= 4'h0;
    end else begin
      if ($signed(sx(evap_temp)) > $signed(fan_hi))
        fan_th_q <= 1'b0;
      else if ($signed(sx(evap_temp)) < $signed(fan_lo))
        fan_th_q <= 1'b1;
      drip_prev_q <= dripping_active;
      if (drip_prev_q && !dripping_active)
        drip_cnt_q <= fan_post_drip_stop_time;
      else if (min_tick_q && drip_cnt_q != 4'h0)
        drip_cnt_q <= drip_cnt_q - 4'h1;
    end
  end

  always @* begin
    case (fan_mode)
      `RFRAC_FAN_ALWAYS: fan_d = !(fan_stop_with_compressor && !comp_run_q);
      `RFRAC_FAN_DIFF:   fan_d = $signed(amb_gap) >= $signed(sx(fan_activation_offset));
      `RFRAC_FAN_EVAP:   fan_d = fan_th_q;
      default:           fan_d = 1'b0;
    endcase
    if (fan_stop_in_defrost && defrost_active)
      fan_d = 1'b0;
    // Drip end edge covers the cycle before the stop count is loaded
    if (dripping_active || drip_prev_q || drip_cnt_q != 4'h0)
      fan_d = 1'b0;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      fan_run_q            <= 1'b0;
      defrost_indication_q <= 1'b0;
    end else begin
      fan_run_q            <= fan_d;
      defrost_indication_q <= defrost_active & ~defrost_display_override;
    end
  end

  // ----------------------------------------
  // Min/max recording
  // ----------------------------------------
  reg        rec_prev_q;
  reg  [5:0] rec_min_q;
  wire       rec_restart = hrs_clr || (minmax_record_enable && !rec_prev_q);

  always @(posedge clock) begin
    if (sys_rst) begin
      rec_prev_q <= 1'b0;
      rec_min_q  <= 6'h0;
      hours_q    <= 8'h0;
      max_q      <= 12'h0;
      min_q      <= 12'h0;
    end else begin
      rec_prev_q <= minmax_record_enable;
      if (rec_restart) begin
        rec_min_q <= 6'h0;
        hours_q   <= 8'h0;
        max_q     <= amb_temp;
        min_q     <= amb_temp;
      end else if (minmax_record_enable) begin
        if ($signed(amb_temp) > $signed(max_q))
          max_q <= amb_temp;
        if ($signed(amb_temp) < $signed(min_q))
          min_q <= amb_temp;
        if (min_tick_q) begin
          if (rec_min_q == `RFRAC_MIN_PER_H) begin
            rec_min_q <= 6'h0;
            if (hours_q != `RFRAC_HOURS_MAX)
              hours_q <= hours_q + 8'h1;
          end else begin
            rec_min_q <= rec_min_q + 6'h1;
          end
        end
      end
    end
  end

endmodule

// ---- src/rfrac_defines.vh ----
// Constants of the refrigeration fan, relay and alarm controller
// Summary of operation
// - Fan mode 0 always on, 1 ambient-evaporator difference, 2 evaporator thermostat.
// - Mode 1 runs fans while evaporator colder than ambient by activation offset.
// - Mode 2 fans off above setpoint plus offset, on below it minus differential.
// - Mode 0 with stop-with-compressor flag holds fans off while compressor is off.
// - Stop-in-defrost flag keeps fans off during defrost in every fan mode.
// - After dripping, fans stay stopped for the post-drip time, 0 to 15 minutes.
// - Relay 4 function: 0 auxiliary, 1 de-energised alarm, 2 energised alarm.
// - Function 1: relay 4 normally off, energises while an alarm exists.
// - Function 2: relay 4 normally energised, drops out on an alarm.
// - Mute returns relay 4 from alarm only once the alarm cause has cleared.
// - Relay 5 is always an alarm output; mute always resets it.
// - Function 0 with an input set to door switch gives light control.
// - Inhibit 0 disables keys, 2 keys and remote, 3 only the remote.
// - With recording enabled track ambient max/min and count hours up to 199.
// - Key press while hours are shown clears hours and restarts recording.
// - Power loss clears hours and extremes; recording restarts with hours at zero. Reset reloads rec_en[8] as 0 here, so recording stays off.
// - Sensor fault: duty 1..99 minutes on then 15 off, 0 off, 100 on.
// - External alarm: its own duty setting drives compressor the same way.
// - Low alarm while temperature below setpoint minus low offset minus differential.
// - High alarm while temperature above setpoint plus high offset plus differential.
// - Defrost indication shown only when the display override setting is 0.
// - Program key held at power-up shows reset and later restores defaults.
// - Low or high alarm offset of zero disables that alarm.
`ifndef RFRAC_DEFINES_VH
`define RFRAC_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RFRAC_CLK_HZ     64'h2625A00
`define RFRAC_MIN_S      64'h3C
`define RFRAC_RST_WAIT_S 64'h3
`define RFRAC_MIN_PER_H  6'h3B
`define RFRAC_HOURS_MAX  8'hC7
`define RFRAC_DUTY_OFF   7'h0F
`define RFRAC_DUTY_ON    7'h64

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFRAC_A_CFG      8'h00
`define RFRAC_A_SETP     8'h04
`define RFRAC_A_ALARM    8'h08
`define RFRAC_A_DIFF     8'h0C
`define RFRAC_A_DUTY     8'h10
`define RFRAC_A_STAT     8'h14
`define RFRAC_A_MINMAX   8'h18
`define RFRAC_A_HOURS    8'h1C

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define RFRAC_FAN_ALWAYS 2'h0
`define RFRAC_FAN_DIFF   2'h1
`define RFRAC_FAN_EVAP   2'h2
`define RFRAC_R4_AUX     2'h0
`define RFRAC_R4_NDE     2'h1
`define RFRAC_R4_NEN     2'h2
`define RFRAC_INH_KEYS   2'h0
`define RFRAC_INH_BOTH   2'h2
`define RFRAC_INH_IR     2'h3
`define RFRAC_IN_DOOR    3'h5

// ----------------------------------------
// Default words and write masks
// ----------------------------------------
// CFG: mode[1:0] stopcmp[2] stopdef[3] r4fn[5:4] inhibit[7:6]
//      rec_en[8] disp_ovr[9] aux[10] postdrip[15:12]
`define RFRAC_CFG_DEF    32'h0000124C
`define RFRAC_CFG_MASK   32'h0000F7FF
// SETP: setpoint[11:0] fan offset[27:16], tenths of a degree
`define RFRAC_SETP_DEF   32'h00320028
`define RFRAC_ALARM_DEF  32'h00000000
`define RFRAC_DIFF_DEF   32'h00000002
// DUTY: sensor[6:0] external[14:8] in1[18:16] in2[22:20]
`define RFRAC_DUTY_DEF   32'h00000000
`define RFRAC_T_MASK     32'h0FFF0FFF
`define RFRAC_DIFF_MASK  32'h00000FFF
`define RFRAC_DUTY_MASK  32'h00777F7F

`endif
